// ---- pkg/asr_pkg.sv ----
// package: register map, field positions, reset values and state encodings
package asr_pkg;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_DATA = 8'h04;
	localparam logic [7:0] ADDR_CTRL1 = 8'h08;
	localparam logic [7:0] ADDR_CTRL2 = 8'h0c;
	localparam logic [7:0] ADDR_BAUD = 8'h10;
	localparam int ST_TX_BUFFER_EMPTY_FLAG = 7;
	localparam int ST_TC = 6;
	localparam int ST_RX_READY_FLAG = 5;
	localparam int ST_IDLE = 4;
	localparam int ST_OVR = 3;
	localparam int ST_NOISE = 2;
	localparam int ST_FERR = 1;
	localparam int C1_RX9 = 7;
	localparam int C1_TX9 = 6;
	localparam int C1_LEN = 4;
	localparam int C1_WAKE = 3;
	localparam int C2_TIE = 7;
	localparam int C2_TX_COMPLETE_IRQ_ENABLE = 6;
	localparam int C2_RIE = 5;
	localparam int C2_IDLE_IRQ_ENABLE = 4;
	localparam int C2_TE = 3;
	localparam int C2_RE = 2;
	localparam int C2_MUTE = 1;
	localparam logic [7:0] STATUS_RESET = 8'hc0;
	localparam logic [7:0] CTRL1_RESET = 8'h00;
	localparam logic [7:0] CTRL2_RESET = 8'h00;
	localparam logic [15:0] BAUD_RESET = 16'h0010;
	localparam logic [3:0] FRAME_SHORT = 4'ha;
	localparam logic [3:0] FRAME_LONG = 4'hb;
	localparam logic [3:0] DATA_SHORT = 4'h8;
	localparam logic [3:0] DATA_LONG = 4'h9;
	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b11,
		RX_STOP = 2'b10
	} asr_rx_state_t;
	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} asr_tx_state_t;
	typedef enum logic [2:0] {
		SEL_NONE = 3'h0,
		SEL_STATUS = 3'h1,
		SEL_DATA = 3'h2,
		SEL_CTRL1 = 3'h3,
		SEL_CTRL2 = 3'h4,
		SEL_BAUD = 3'h5
	} asr_sel_t;
endpackage

// ---- hdl/asr_rx_frame.sv ----
// receive framer: start hunt, 3-sample majority, noise, framing and idle detection
`timescale 1ns/100ps
`default_nettype none
module asr_rx_frame (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rx_line,
	input wire logic rx_on,
	input wire logic run,
	input wire logic [15:0] bit_div,
	input wire logic nine_bit,
	output logic word_valid,
	output logic [8:0] word,
	output logic word_noise,
	output logic word_framing,
	output logic idle_seen
);
	typedef struct packed {
		asr_pkg::asr_rx_state_t st;
		logic [15:0] cnt;
		logic [3:0] nbit;
		logic [8:0] shf;
		logic [2:0] smp;
		logic noisy;
		logic [3:0] idle_bits;
		logic idle_done;
		logic vld;
		logic nf;
		logic fe;
		logic idle_p;
	} asr_rx_st_t;

	asr_rx_st_t s_ff;
	asr_rx_st_t nxt_s;

	function automatic logic asr_major(input logic [2:0] v);
		asr_major = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	always_comb begin
		logic [15:0] half;
		logic wrap;
		logic decide;
		logic bitv;
		logic clean;
		logic [3:0] frame_bits;
		logic [3:0] data_bits;
		half = {1'b0, bit_div[15:1]};
		wrap = s_ff.cnt == bit_div - 16'h0001;
		decide = s_ff.cnt == half + 16'h0001;
		bitv = asr_major(s_ff.smp);
		clean = (s_ff.smp == 3'h0) || (s_ff.smp == 3'h7);
		frame_bits = nine_bit ? asr_pkg::FRAME_LONG : asr_pkg::FRAME_SHORT;
		data_bits = nine_bit ? asr_pkg::DATA_LONG : asr_pkg::DATA_SHORT;
		nxt_s = s_ff;
		nxt_s.vld = 1'b0;
		nxt_s.idle_p = 1'b0;
		if (!rx_on) begin
			nxt_s.st = asr_pkg::RX_HUNT;
			nxt_s.cnt = 16'h0000;
			nxt_s.idle_bits = 4'h0;
			nxt_s.idle_done = 1'b0;
		end else if (run) begin
			nxt_s.cnt = wrap ? 16'h0000 : s_ff.cnt + 16'h0001;
			if (s_ff.cnt == half - 16'h0002 || s_ff.cnt == half - 16'h0001 || s_ff.cnt == half) begin
				nxt_s.smp = {s_ff.smp[1:0], rx_line};
			end
			case (s_ff.st)
				asr_pkg::RX_HUNT: begin
					if (!rx_line) begin
						nxt_s.st = asr_pkg::RX_START;
						nxt_s.cnt = 16'h0001;
						// the detection sample stands in when the first sample point already lies behind
						nxt_s.smp = 3'h0;
						nxt_s.noisy = 1'b0;
						nxt_s.idle_bits = 4'h0;
						nxt_s.idle_done = 1'b0;
					end else if (wrap && !s_ff.idle_done) begin
						nxt_s.idle_bits = s_ff.idle_bits + 4'h1;
						if (s_ff.idle_bits == frame_bits - 4'h1) begin
							nxt_s.idle_p = 1'b1;
							nxt_s.idle_done = 1'b1;
						end
					end
				end
				asr_pkg::RX_START: begin
					if (wrap) begin
						nxt_s.st = asr_pkg::RX_DATA;
						nxt_s.nbit = 4'h0;
					end
					// a false start wins even when the decision falls on the last count of the bit
					if (decide) begin
						nxt_s.noisy = !clean;
						if (bitv) begin
							nxt_s.st = asr_pkg::RX_HUNT;
						end
					end
				end
				asr_pkg::RX_DATA: begin
					if (decide) begin
						nxt_s.shf = {bitv, s_ff.shf[8:1]};
						nxt_s.noisy = s_ff.noisy | !clean;
						nxt_s.nbit = s_ff.nbit + 4'h1;
					end
					if (wrap && nxt_s.nbit == data_bits) begin
						nxt_s.st = asr_pkg::RX_STOP;
					end
				end
				asr_pkg::RX_STOP: begin
					if (decide) begin
						nxt_s.vld = 1'b1;
						nxt_s.nf = s_ff.noisy | !clean;
						nxt_s.fe = !bitv;
						nxt_s.st = asr_pkg::RX_HUNT;
					end
				end
				default: begin
					nxt_s.st = asr_pkg::RX_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign word_valid = s_ff.vld;
	assign word = nine_bit ? s_ff.shf : {1'b0, s_ff.shf[8:1]};
	assign word_noise = s_ff.nf;
	assign word_framing = s_ff.fe;
	assign idle_seen = s_ff.idle_p;
endmodule
`default_nettype wire

// ---- hdl/asr_serial.sv ----
// serial interface with mute/wake-up, status flags, control registers, APB slave
`timescale 1ns/100ps
`default_nettype none
module asr_serial (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_irq_mask,
	input wire logic halt_mode,
	input wire logic serial_rx_pin,
	output logic tx_pin_out,
	output logic tx_pin_oe,
	output logic irq_request
);
	typedef struct packed {
		logic tx_buffer_empty_flag;
		logic tc;
		logic rx_ready_flag;
		logic idle;
		logic ovr;
		logic noise;
		logic ferr;
		logic rx9;
		logic tx9;
		logic len;
		logic wake;
		logic tx_empty_irq_enable;
		logic tx_complete_irq_enable;
		logic rx_irq_enable;
		logic idle_irq_enable;
		logic te;
		logic re;
		logic mute;
		logic [15:0] baud;
		logic [7:0] rx_buf;
		logic [7:0] tx_buf;
		logic seen;
		logic idle_arm;
		logic rx_meta;
		logic rx_sync;
		asr_pkg::asr_tx_state_t tx_st;
		logic [15:0] tx_cnt;
		logic [3:0] tx_left;
		logic [10:0] tx_shf;
		logic pre_pend;
		logic te_prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic tx_out;
		logic tx_oe;
	} asr_state_t;

	asr_state_t s_ff;
	asr_state_t nxt_s;
	logic rx_vld;
	logic [8:0] rx_word;
	logic rx_nf;
	logic rx_fe;
	logic rx_idle;

	function automatic asr_pkg::asr_sel_t asr_decode(input logic [7:0] a);
		case (a)
			asr_pkg::ADDR_STATUS: asr_decode = asr_pkg::SEL_STATUS;
			asr_pkg::ADDR_DATA: asr_decode = asr_pkg::SEL_DATA;
			asr_pkg::ADDR_CTRL1: asr_decode = asr_pkg::SEL_CTRL1;
			asr_pkg::ADDR_CTRL2: asr_decode = asr_pkg::SEL_CTRL2;
			asr_pkg::ADDR_BAUD: asr_decode = asr_pkg::SEL_BAUD;
			default: asr_decode = asr_pkg::SEL_NONE;
		endcase
	endfunction

	asr_rx_frame u_rx (
		.pclk(pclk),
		.presetn(presetn),
		.rx_line(s_ff.rx_sync),
		.rx_on(s_ff.re),
		.run(!halt_mode),
		.bit_div(s_ff.baud),
		.nine_bit(s_ff.len),
		.word_valid(rx_vld),
		.word(rx_word),
		.word_noise(rx_nf),
		.word_framing(rx_fe),
		.idle_seen(rx_idle)
	);

	always_comb begin
		asr_pkg::asr_sel_t sel;
		logic access;
		logic rd;
		logic wr;
		logic msb;
		logic take;
		logic [7:0] st_val;
		logic [3:0] frame_bits;
		sel = asr_decode(paddr);
		access = psel && penable && s_ff.pready;
		rd = access && !pwrite;
		wr = access && pwrite && !halt_mode;
		frame_bits = s_ff.len ? asr_pkg::FRAME_LONG : asr_pkg::FRAME_SHORT;
		st_val = 8'h00;
		st_val[asr_pkg::ST_TX_BUFFER_EMPTY_FLAG] = s_ff.tx_buffer_empty_flag;
		st_val[asr_pkg::ST_TC] = s_ff.tc;
		st_val[asr_pkg::ST_RX_READY_FLAG] = s_ff.rx_ready_flag;
		st_val[asr_pkg::ST_IDLE] = s_ff.idle;
		st_val[asr_pkg::ST_OVR] = s_ff.ovr;
		st_val[asr_pkg::ST_NOISE] = s_ff.noise;
		st_val[asr_pkg::ST_FERR] = s_ff.ferr;
		nxt_s = s_ff;
		nxt_s.rx_meta = serial_rx_pin;
		nxt_s.rx_sync = s_ff.rx_meta;

		// apb: no wait state, answer registered at the setup edge
		nxt_s.pready = psel && !penable;
		if (psel && !penable) begin
			nxt_s.pslverr = sel == asr_pkg::SEL_NONE;
			nxt_s.prdata = 32'h0000_0000;
			case (sel)
				asr_pkg::SEL_STATUS: nxt_s.prdata[7:0] = st_val;
				asr_pkg::SEL_DATA: nxt_s.prdata[7:0] = s_ff.rx_buf;
				asr_pkg::SEL_CTRL1: begin
					nxt_s.prdata[asr_pkg::C1_RX9] = s_ff.rx9;
					nxt_s.prdata[asr_pkg::C1_TX9] = s_ff.tx9;
					nxt_s.prdata[asr_pkg::C1_LEN] = s_ff.len;
					nxt_s.prdata[asr_pkg::C1_WAKE] = s_ff.wake;
				end
				asr_pkg::SEL_CTRL2: begin
					nxt_s.prdata[asr_pkg::C2_TIE] = s_ff.tx_empty_irq_enable;
					nxt_s.prdata[asr_pkg::C2_TX_COMPLETE_IRQ_ENABLE] = s_ff.tx_complete_irq_enable;
					nxt_s.prdata[asr_pkg::C2_RIE] = s_ff.rx_irq_enable;
					nxt_s.prdata[asr_pkg::C2_IDLE_IRQ_ENABLE] = s_ff.idle_irq_enable;
					nxt_s.prdata[asr_pkg::C2_TE] = s_ff.te;
					nxt_s.prdata[asr_pkg::C2_RE] = s_ff.re;
					nxt_s.prdata[asr_pkg::C2_MUTE] = s_ff.mute;
				end
				asr_pkg::SEL_BAUD: nxt_s.prdata[15:0] = s_ff.baud;
				default: nxt_s.prdata = 32'h0000_0000;
			endcase
		end

		// status access arms the clearing sequence, the data access completes it
		if (access && !halt_mode && sel == asr_pkg::SEL_STATUS) begin
			nxt_s.seen = 1'b1;
		end
		if (access && !halt_mode && sel == asr_pkg::SEL_DATA) begin
			nxt_s.seen = 1'b0;
			if (s_ff.seen && pwrite) begin
				nxt_s.tx_buffer_empty_flag = 1'b0;
				nxt_s.tc = 1'b0;
			end
			if (s_ff.seen && !pwrite) begin
				nxt_s.rx_ready_flag = 1'b0;
				nxt_s.idle = 1'b0;
				nxt_s.ovr = 1'b0;
				nxt_s.noise = 1'b0;
				nxt_s.ferr = 1'b0;
			end
		end
		if (wr) begin
			case (sel)
				asr_pkg::SEL_DATA: nxt_s.tx_buf = pwdata[7:0];
				asr_pkg::SEL_CTRL1: begin
					nxt_s.tx9 = pwdata[asr_pkg::C1_TX9];
					nxt_s.len = pwdata[asr_pkg::C1_LEN];
					nxt_s.wake = pwdata[asr_pkg::C1_WAKE];
				end
				asr_pkg::SEL_CTRL2: begin
					nxt_s.tx_empty_irq_enable = pwdata[asr_pkg::C2_TIE];
					nxt_s.tx_complete_irq_enable = pwdata[asr_pkg::C2_TX_COMPLETE_IRQ_ENABLE];
					nxt_s.rx_irq_enable = pwdata[asr_pkg::C2_RIE];
					nxt_s.idle_irq_enable = pwdata[asr_pkg::C2_IDLE_IRQ_ENABLE];
					nxt_s.te = pwdata[asr_pkg::C2_TE];
					nxt_s.re = pwdata[asr_pkg::C2_RE];
					nxt_s.mute = pwdata[asr_pkg::C2_MUTE];
				end
				asr_pkg::SEL_BAUD: nxt_s.baud = pwdata[15:0];
				default: nxt_s.baud = s_ff.baud;
			endcase
		end
		if (!halt_mode) begin
			nxt_s.te_prev = s_ff.te;
		end

		// transmitter
		if (!halt_mode) begin
			if (s_ff.te && !s_ff.te_prev) begin
				nxt_s.pre_pend = 1'b1;
			end
			case (s_ff.tx_st)
				asr_pkg::TX_IDLE: begin
					nxt_s.tx_cnt = 16'h0000;
					nxt_s.tx_left = frame_bits;
					if (s_ff.te && s_ff.pre_pend) begin
						nxt_s.tx_shf = 11'h7ff;
						nxt_s.pre_pend = 1'b0;
						nxt_s.tx_st = asr_pkg::TX_SEND;
					end else if (s_ff.te && !s_ff.tx_buffer_empty_flag) begin
						nxt_s.tx_shf = s_ff.len ? {1'b1, s_ff.tx9, s_ff.tx_buf, 1'b0} : {2'b11, s_ff.tx_buf, 1'b0};
						nxt_s.tx_buffer_empty_flag = 1'b1;
						nxt_s.tx_st = asr_pkg::TX_SEND;
					end
				end
				asr_pkg::TX_SEND: begin
					nxt_s.tx_cnt = s_ff.tx_cnt + 16'h0001;
					if (s_ff.tx_cnt == s_ff.baud - 16'h0001) begin
						nxt_s.tx_cnt = 16'h0000;
						nxt_s.tx_shf = {1'b1, s_ff.tx_shf[10:1]};
						nxt_s.tx_left = s_ff.tx_left - 4'h1;
						if (s_ff.tx_left == 4'h1) begin
							nxt_s.tc = 1'b1;
							nxt_s.tx_st = asr_pkg::TX_IDLE;
						end
					end
				end
				default: nxt_s.tx_st = asr_pkg::TX_IDLE;
			endcase
		end
		nxt_s.tx_oe = nxt_s.te;
		nxt_s.tx_out = (nxt_s.tx_st == asr_pkg::TX_SEND) ? nxt_s.tx_shf[0] : 1'b1;

		// receiver events
		msb = s_ff.len ? rx_word[8] : rx_word[7];
		take = 1'b0;
		if (rx_vld) begin
			if (!s_ff.mute) begin
				take = 1'b1;
			end else if (s_ff.wake && msb) begin
				nxt_s.mute = 1'b0;
				take = 1'b1;
			end
		end
		if (take) begin
			if (nxt_s.rx_ready_flag) begin
				nxt_s.ovr = 1'b1;
			end else begin
				nxt_s.rx_buf = rx_word[7:0];
				nxt_s.rx9 = rx_word[8] & s_ff.len;
				nxt_s.rx_ready_flag = 1'b1;
				nxt_s.noise = rx_nf;
				nxt_s.ferr = rx_fe;
				nxt_s.idle_arm = 1'b1;
			end
		end
		if (rx_idle) begin
			if (s_ff.mute) begin
				if (!s_ff.wake) begin
					nxt_s.mute = 1'b0;
				end
			end else if (s_ff.idle_arm) begin
				nxt_s.idle = 1'b1;
				nxt_s.idle_arm = 1'b0;
			end
		end

		// one shared request; receive sources gated off while muted, none while halted
		nxt_s.irq = !cpu_irq_mask && !halt_mode && (
			(nxt_s.tx_empty_irq_enable && nxt_s.tx_buffer_empty_flag) ||
			(nxt_s.tx_complete_irq_enable && nxt_s.tc) ||
			(!nxt_s.mute && nxt_s.rx_irq_enable && (nxt_s.rx_ready_flag || nxt_s.ovr)) ||
			(!nxt_s.mute && nxt_s.idle_irq_enable && nxt_s.idle));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
			s_ff.tx_buffer_empty_flag <= asr_pkg::STATUS_RESET[asr_pkg::ST_TX_BUFFER_EMPTY_FLAG];
			s_ff.tc <= asr_pkg::STATUS_RESET[asr_pkg::ST_TC];
			s_ff.rx9 <= asr_pkg::CTRL1_RESET[asr_pkg::C1_RX9];
			s_ff.te <= asr_pkg::CTRL2_RESET[asr_pkg::C2_TE];
			s_ff.baud <= asr_pkg::BAUD_RESET;
			s_ff.idle_arm <= 1'b1;
			s_ff.rx_meta <= 1'b1;
			s_ff.rx_sync <= 1'b1;
			s_ff.tx_st <= asr_pkg::TX_IDLE;
			s_ff.tx_out <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata = s_ff.prdata;
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign tx_pin_out = s_ff.tx_out;
	assign tx_pin_oe = s_ff.tx_oe;
	assign irq_request = s_ff.irq;
endmodule
`default_nettype wire

// ---- verification/asr_serial_props.sv ----
// concurrent checks on the serial interface ports
`timescale 1ns/100ps
`default_nettype none
module asr_serial_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic cpu_irq_mask,
	input wire logic halt_mode,
	input wire logic tx_pin_out,
	input wire logic tx_pin_oe,
	input wire logic irq_request
);
	logic done;
	logic wr_c2;
	logic [3:0] en_ff;
	logic [3:0] en_prev_ff;
	assign done = psel && penable && pready;
	assign wr_c2 = done && pwrite && !halt_mode && paddr == asr_pkg::ADDR_CTRL2;
	// mirror of the interrupt enables with one cycle of history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_ff <= 4'h0;
			en_prev_ff <= 4'h0;
		end else begin
			en_prev_ff <= en_ff;
			if (wr_c2) begin
				en_ff <= pwdata[7:4];
			end
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_APB_ANSWER:
		assert property (psel && !penable |=> pready) else $error("no answer in access cycle");
	AST_STATUS_LAYOUT:
		assert property (done && !pwrite && paddr == asr_pkg::ADDR_STATUS |-> prdata[31:8] == 24'h00_0000 && !prdata[0])
		else $error("status unused bits set");
	AST_CTRL2_LAYOUT:
		assert property (done && !pwrite && paddr == asr_pkg::ADDR_CTRL2 |-> prdata[31:8] == 24'h00_0000 && !prdata[0])
		else $error("control two unused bits set");
	AST_MASK_GATES:
		assert property (cpu_irq_mask && $past(cpu_irq_mask) |-> !irq_request) else $error("irq while masked");
	AST_ENABLE_GATES:
		assert property (en_ff == 4'h0 && en_prev_ff == 4'h0 |-> !irq_request) else $error("irq with no enable");
	AST_HALT_NO_IRQ:
		assert property (halt_mode && $past(halt_mode) |-> !irq_request) else $error("irq in halt");
	AST_HALT_FREEZE:
		assert property (halt_mode |=> $stable(tx_pin_out)) else $error("tx line moved in halt");
	AST_TE_ON:
		assert property (wr_c2 && pwdata[3] |-> ##[1:2] tx_pin_oe) else $error("pin not taken");
	AST_TE_OFF:
		assert property (wr_c2 && !pwdata[3] |-> ##[1:2] !tx_pin_oe) else $error("pin not released");
endmodule
bind asr_serial asr_serial_props asr_serial_props_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .cpu_irq_mask(cpu_irq_mask),
	.halt_mode(halt_mode), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .irq_request(irq_request)
);
`default_nettype wire

// ---- verification/asr_node.sv ----
// far serial node: sends words on the receive line, captures transmitted words
`timescale 1ns/100ps
`default_nettype none
module asr_node #(
	parameter int BAUD = 4
) (
	input wire logic pclk,
	input wire logic tx_line,
	output logic rx_line,
	output logic [7:0] got,
	output logic [7:0] got_count
);
	initial begin
		rx_line = 1'b1;
		got = 8'h00;
		got_count = 8'h00;
	end
	task automatic send(input logic [7:0] w);
		logic [9:0] f;
		f = {1'b1, w, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge pclk);
			rx_line <= f[i];
			repeat (BAUD - 1) @(posedge pclk);
		end
	endtask
	always begin
		@(negedge tx_line);
		repeat (BAUD / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BAUD) @(posedge pclk);
			got[i] <= tx_line;
		end
		repeat (BAUD) @(posedge pclk);
		got_count <= got_count + 8'h01;
	end
endmodule
`default_nettype wire

// ---- verification/asr_serial_tb.sv ----
// testbench for the serial interface: registers, transmit, receive, mute, halt
`timescale 1ns/100ps
`default_nettype none
module asr_serial_tb;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} asr_row_t;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, cpu_irq_mask, halt_mode;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready, pslverr, tx_pin_out, tx_pin_oe, irq_request, rx_line, e;
	logic [7:0] got, got_count;
	logic [31:0] r;
	int miscompares = 0;
	int check_count = 0;
	asr_row_t rows [7] = '{'{8'h08, 8'h58, 8'h58, 1'b0}, '{8'h08, 8'h80, 8'h00, 1'b0},
		'{8'h0c, 8'hf6, 8'hf6, 1'b0}, '{8'h0c, 8'h01, 8'h00, 1'b0}, '{8'h00, 8'h00, 8'hc0, 1'b0},
		'{8'h14, 8'hff, 8'h00, 1'b1}, '{8'h10, 8'h04, 8'h04, 1'b0}};
	always #20 pclk = ~pclk;
	asr_serial asr_serial_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode), .serial_rx_pin(rx_line),
		.tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .irq_request(irq_request));
	asr_node #(.BAUD(4)) asr_node_i (.pclk(pclk), .tx_line(tx_pin_out), .rx_line(rx_line), .got(got),
		.got_count(got_count));
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			$display("ERROR at %0t: seen %h expected %h", $time, seen, want);
			miscompares++;
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ok;
		n = 0;
		ok = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// answer read while settled; it stands unchanged up to the rising edge that completes the access
		while (!ok && n < 20) begin
			@(negedge pclk);
			ok = pready === 1'b1;
			r = prdata;
			e = pslverr;
			@(posedge pclk);
			n++;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (!ok) begin
			miscompares++;
			print_verdict();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] q);
		apb(1'b0, a, 32'h0000_0000);
		chk(r & m, q);
	endtask
	task automatic wait_st(input int b);
		int n;
		n = 0;
		do begin
			apb(1'b0, asr_pkg::ADDR_STATUS, 32'h0000_0000);
			n++;
		end while (r[b] !== 1'b1 && n < 400);
		chk(32'(r[b]), 32'h0000_0001);
		if (r[b] !== 1'b1) print_verdict();
	endtask
	task automatic wait_got(input logic [7:0] n, input logic [7:0] w);
		for (int k = 0; k < 400 && got_count !== n; k++) @(posedge pclk);
		chk(32'(got_count), 32'(n));
		chk(32'(got), 32'(w));
		if (got_count !== n) print_verdict();
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		cpu_irq_mask = 1'b0;
		halt_mode = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(asr_pkg::ADDR_STATUS, 32'hffff_ffff, 32'h0000_00c0);
		rd(asr_pkg::ADDR_CTRL2, 32'hffff_ffff, 32'h0000_0000);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, 32'(rows[i].d));
			rd(rows[i].a, 32'hffff_ffff, 32'(rows[i].q));
			chk(32'(e), 32'(rows[i].e));
		end
		apb(1'b1, asr_pkg::ADDR_CTRL2, 32'h0000_0008);
		rd(asr_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0000);
		chk(32'(tx_pin_oe), 32'h0000_0001);
		apb(1'b1, asr_pkg::ADDR_DATA, 32'h0000_00a5);
		rd(asr_pkg::ADDR_STATUS, 32'h0000_00c0, 32'h0000_0000);
		wait_got(8'h01, 8'ha5);
		wait_st(asr_pkg::ST_TC);
		apb(1'b1, asr_pkg::ADDR_DATA, 32'h0000_0011);
		apb(1'b1, asr_pkg::ADDR_DATA, 32'h0000_0077);
		wait_st(asr_pkg::ST_TC);
		wait_got(8'h02, 8'h11);
		apb(1'b1, asr_pkg::ADDR_CTRL2, 32'h0000_0004);
		asr_node_i.send(8'h5a);
		wait_st(asr_pkg::ST_RX_READY_FLAG);
		rd(asr_pkg::ADDR_DATA, 32'h0000_00ff, 32'h0000_005a);
		rd(asr_pkg::ADDR_STATUS, 32'h0000_0020, 32'h0000_0000);
		asr_node_i.send(8'h11);
		asr_node_i.send(8'h22);
		repeat (4) @(posedge pclk);
		rd(asr_pkg::ADDR_STATUS, 32'h0000_0028, 32'h0000_0028);
		rd(asr_pkg::ADDR_DATA, 32'h0000_00ff, 32'h0000_0011);
		rd(asr_pkg::ADDR_STATUS, 32'h0000_002e, 32'h0000_0000);
		apb(1'b1, asr_pkg::ADDR_CTRL2, 32'h0000_0024);
		asr_node_i.send(8'h44);
		wait_st(asr_pkg::ST_RX_READY_FLAG);
		repeat (3) @(posedge pclk);
		chk(32'(irq_request), 32'h0000_0001);
		cpu_irq_mask <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'(irq_request), 32'h0000_0000);
		cpu_irq_mask <= 1'b0;
		halt_mode <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(32'(irq_request), 32'h0000_0000);
		halt_mode <= 1'b0;
		rd(asr_pkg::ADDR_DATA, 32'h0000_00ff, 32'h0000_0044);
		repeat (3) @(posedge pclk);
		chk(32'(irq_request), 32'h0000_0000);
		apb(1'b1, asr_pkg::ADDR_CTRL1, 32'h0000_0008);
		apb(1'b1, asr_pkg::ADDR_CTRL2, 32'h0000_0026);
		asr_node_i.send(8'h12);
		repeat (4) @(posedge pclk);
		chk(32'(irq_request), 32'h0000_0000);
		rd(asr_pkg::ADDR_STATUS, 32'h0000_002e, 32'h0000_0000);
		rd(asr_pkg::ADDR_CTRL2, 32'h0000_0002, 32'h0000_0002);
		asr_node_i.send(8'h92);
		wait_st(asr_pkg::ST_RX_READY_FLAG);
		rd(asr_pkg::ADDR_DATA, 32'h0000_00ff, 32'h0000_0092);
		rd(asr_pkg::ADDR_CTRL2, 32'h0000_0002, 32'h0000_0000);
		rd(asr_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0000);
		rd(asr_pkg::ADDR_DATA, 32'h0000_0000, 32'h0000_0000);
		// muted again before the line behind the address word goes idle, with the idle flag still armed
		apb(1'b1, asr_pkg::ADDR_CTRL1, 32'h0000_0000);
		apb(1'b1, asr_pkg::ADDR_CTRL2, 32'h0000_0006);
		repeat (80) @(posedge pclk);
		rd(asr_pkg::ADDR_CTRL2, 32'h0000_0002, 32'h0000_0000);
		rd(asr_pkg::ADDR_STATUS, 32'h0000_0030, 32'h0000_0000);
		// reset in mid-run after the receiver was left enabled
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'({tx_pin_out, tx_pin_oe, irq_request}), 32'h0000_0004);
		presetn <= 1'b1;
		rd(asr_pkg::ADDR_CTRL2, 32'hffff_ffff, 32'h0000_0000);
		rd(asr_pkg::ADDR_STATUS, 32'hffff_ffff, 32'(asr_pkg::STATUS_RESET));
		print_verdict();
	end
endmodule
`default_nettype wire
